// ---- wpis_map.vh ----
// Constants for the wiper serial slave port
`ifndef WPIS_MAP_VH
`define WPIS_MAP_VH

// Register offset and reset value
`define WPIS_WIPER_ADDR 8'h00
`define WPIS_WIPER_RESET 8'h80
// Identity byte field positions
`define WPIS_ID_MSB 7
`define WPIS_ID_LSB 1
`define WPIS_RW_BIT 0
// Bits per byte on the wire
`define WPIS_BYTE_BITS 4'd8
// Power-up window and the clock period, both in ns
`define WPIS_PWRUP_NS 128
`define WPIS_CLK_NS 8
`define WPIS_PWRUP_CYC (`WPIS_PWRUP_NS / `WPIS_CLK_NS)

`endif

// ---- wpis_sync.v ----
// Two-stage synchroniser for one bus line
`timescale 1ns/100ps
`default_nettype none

module wpis_sync (
  // Clock and reset
  input wire CLK,
  input wire RST,
  // Asynchronous line and its synchronised level
  input wire LINE_IN,
  output wire LINE_SYNC
);

  reg stage1;
  reg stage2;

  // Lines idle high, so both stages reset high
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      stage1 <= 1'b1;
      stage2 <= 1'b1;
    end else begin
      stage1 <= LINE_IN;
      stage2 <= stage1;
    end
  end

  assign LINE_SYNC = stage2;

endmodule // wpis_sync

`default_nettype wire

// ---- wpis_slave.v ----
// Two-wire slave port owning the eight-bit wiper position register
`timescale 1ns/100ps
`default_nettype none
`include "wpis_map.vh"

module wpis_slave #(
  // Device code; value is arbitrary
  parameter [6:0] DEV_CODE = 7'h2a,
  // Power-up window in clock cycles
  parameter integer PWRUP_CYC = `WPIS_PWRUP_CYC
) (
  // Clock and reset
  input wire CLK,
  input wire RST,
  // Serial clock from the master, sampled only
  input wire SCL_IN,
  // Serial data, open drain
  input wire SDA_IN,
  output wire SDA_OUT,
  output wire SDA_OE,
  // Wiper position and its update pulse
  output wire [7:0] WIPER,
  output wire WIPER_LOAD,
  // Status
  output wire BUSY
);

  // Protocol states
  localparam [3:0] ST_IDLE = 4'h0;
  localparam [3:0] ST_IDRX = 4'h1;
  localparam [3:0] ST_IDACK = 4'h2;
  localparam [3:0] ST_ADRX = 4'h3;
  localparam [3:0] ST_ADACK = 4'h4;
  localparam [3:0] ST_WRX = 4'h5;
  localparam [3:0] ST_WACK = 4'h6;
  localparam [3:0] ST_TX = 4'h7;
  localparam [3:0] ST_MACK = 4'h8;
  localparam [3:0] ST_IGNORE = 4'h9;

  // Power-up counter width
  localparam integer PW = 16;

  wire scl_s;
  wire sda_s;
  reg scl_prev;
  reg sda_prev;
  reg [PW-1:0] pwr_cnt;
  reg ready;
  reg [3:0] state;
  reg [3:0] bit_cnt;
  reg [7:0] shift;
  reg [7:0] hold;
  reg [7:0] wiper;
  reg drive;
  reg nine;
  reg mack;
  reg rd_dir;
  reg load;
  reg [3:0] next_state;
  reg [3:0] next_bit_cnt;
  reg [7:0] next_shift;
  reg [7:0] next_hold;
  reg [7:0] next_wiper;
  reg next_drive;
  reg next_nine;
  reg next_mack;
  reg next_rd_dir;
  reg next_load;

  wire scl_rise;
  wire scl_fall;
  wire start_evt;
  wire stop_evt;

  // True when the identity byte carries our device code
  function id_match;
    input [7:0] b;
    begin
      id_match = (b[`WPIS_ID_MSB:`WPIS_ID_LSB] == DEV_CODE);
    end
  endfunction

  // Shift a sampled bit in at the bottom, so the first bit ends on top
  function [7:0] shift_in;
    input [7:0] b;
    input d;
    begin
      shift_in = {b[6:0], d};
    end
  endfunction

  // Count one more bit, saturating at eight
  function [3:0] count_up;
    input [3:0] c;
    begin
      if (c >= `WPIS_BYTE_BITS)
        count_up = c;
      else
        count_up = c + 4'd1;
    end
  endfunction

  // Both bus lines pass two flops before any logic reads them
  wpis_sync u_scl_sync (
    .CLK(CLK),
    .RST(RST),
    .LINE_IN(SCL_IN),
    .LINE_SYNC(scl_s)
  );

  wpis_sync u_sda_sync (
    .CLK(CLK),
    .RST(RST),
    .LINE_IN(SDA_IN),
    .LINE_SYNC(sda_s)
  );

  // Previous levels for edge detection
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_prev <= scl_s;
      sda_prev <= sda_s;
    end
  end

  // Edges of the master's clock; the master alone supplies it
  assign scl_rise = scl_s & ~scl_prev;
  assign scl_fall = ~scl_s & scl_prev;

  // Data edges with the clock held high are START and STOP
  assign start_evt = sda_prev & ~sda_s & scl_s & scl_prev;
  assign stop_evt = ~sda_prev & sda_s & scl_s & scl_prev;

  // Power-up window: the engine stays idle until it runs out
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      pwr_cnt <= {PW{1'b0}};
      ready <= 1'b0;
    end else if (!ready) begin
      if (pwr_cnt >= PWRUP_CYC[PW-1:0] - {{(PW-1){1'b0}}, 1'b1})
        ready <= 1'b1;
      pwr_cnt <= pwr_cnt + {{(PW-1){1'b0}}, 1'b1};
    end
  end

  // Protocol engine, next values
  always @* begin
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_shift = shift;
    next_hold = hold;
    next_wiper = wiper;
    next_drive = drive;
    next_nine = nine;
    next_mack = mack;
    next_rd_dir = rd_dir;
    next_load = 1'b0;
    if (!ready) begin
      // START during power-up is disregarded
      next_state = ST_IDLE;
      next_drive = 1'b0;
    end else if (start_evt) begin
      // Any START, first or repeated, opens a new identity byte
      next_state = ST_IDRX;
      next_bit_cnt = 4'd0;
      next_drive = 1'b0;
      next_nine = 1'b0;
    end else if (stop_evt) begin
      // STOP returns to standby from any state
      next_state = ST_IDLE;
      next_drive = 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          // Nothing is answered until a START
          next_drive = 1'b0;
        end
        ST_IDRX: begin
          // Sample on the rising clock, most significant bit first
          if (scl_rise) begin
            next_shift = shift_in(shift, sda_s);
            next_bit_cnt = count_up(bit_cnt);
          end else if (scl_fall && bit_cnt == `WPIS_BYTE_BITS) begin
            next_nine = 1'b0;
            if (id_match(shift)) begin
              // Valid identity: pull low for the ninth clock
              next_rd_dir = shift[`WPIS_RW_BIT];
              next_state = ST_IDACK;
              next_drive = 1'b1;
            end else begin
              // Foreign identity: stay released and wait for START
              next_state = ST_IGNORE;
              next_drive = 1'b0;
            end
          end
        end
        ST_IDACK: begin
          if (scl_rise) begin
            next_nine = 1'b1;
          end else if (scl_fall && nine) begin
            next_bit_cnt = 4'd0;
            next_nine = 1'b0;
            if (rd_dir) begin
              // Read direction: load the wiper and drive its top bit
              next_state = ST_TX;
              next_shift = {wiper[6:0], 1'b0};
              next_drive = ~wiper[7];
            end else begin
              next_state = ST_ADRX;
              next_drive = 1'b0;
            end
          end
        end
        ST_ADRX: begin
          if (scl_rise) begin
            next_shift = shift_in(shift, sda_s);
            next_bit_cnt = count_up(bit_cnt);
          end else if (scl_fall && bit_cnt == `WPIS_BYTE_BITS) begin
            next_nine = 1'b0;
            if (shift == `WPIS_WIPER_ADDR) begin
              // Only address 00h selects the wiper; acknowledge it
              next_state = ST_ADACK;
              next_drive = 1'b1;
            end else begin
              // Bad address blocks any write
              next_state = ST_IGNORE;
              next_drive = 1'b0;
            end
          end
        end
        ST_ADACK: begin
          if (scl_rise) begin
            next_nine = 1'b1;
          end else if (scl_fall && nine) begin
            // A data byte follows unless a repeated START comes first
            next_state = ST_WRX;
            next_bit_cnt = 4'd0;
            next_nine = 1'b0;
            next_drive = 1'b0;
          end
        end
        ST_WRX: begin
          if (scl_rise) begin
            // Data enters the holding register bit by bit
            next_hold = shift_in(hold, sda_s);
            next_bit_cnt = count_up(bit_cnt);
          end else if (scl_fall && bit_cnt == `WPIS_BYTE_BITS) begin
            // Falling edge after the LSB commits the byte
            next_wiper = hold;
            next_load = 1'b1;
            next_state = ST_WACK;
            next_drive = 1'b1;
            next_nine = 1'b0;
          end
        end
        ST_WACK: begin
          if (scl_rise) begin
            next_nine = 1'b1;
          end else if (scl_fall && nine) begin
            // One data byte per write; then wait for STOP
            next_state = ST_IGNORE;
            next_drive = 1'b0;
          end
        end
        ST_TX: begin
          if (scl_rise) begin
            next_bit_cnt = count_up(bit_cnt);
          end else if (scl_fall) begin
            if (bit_cnt == `WPIS_BYTE_BITS) begin
              // Eight bits sent: release for the master's answer
              next_state = ST_MACK;
              next_drive = 1'b0;
              next_nine = 1'b0;
              next_mack = 1'b0;
            end else begin
              // Next bit, changed only while the clock is low
              next_drive = ~shift[7];
              next_shift = {shift[6:0], 1'b0};
            end
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            next_nine = 1'b1;
            next_mack = ~sda_s;
          end else if (scl_fall && nine) begin
            next_nine = 1'b0;
            next_bit_cnt = 4'd0;
            if (mack) begin
              // Master acknowledged: send the wiper again
              next_state = ST_TX;
              next_shift = {wiper[6:0], 1'b0};
              next_drive = ~wiper[7];
            end else begin
              // No acknowledge ends the read; STOP follows
              next_state = ST_IGNORE;
              next_drive = 1'b0;
            end
          end
        end
        ST_IGNORE: begin
          next_drive = 1'b0;
        end
        default: begin
          next_state = ST_IDLE;
          next_drive = 1'b0;
        end
      endcase
    end
  end

  // Protocol engine registers; wiper presets to mid-scale
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      state <= ST_IDLE;
      bit_cnt <= 4'd0;
      shift <= 8'h00;
      hold <= 8'h00;
      wiper <= `WPIS_WIPER_RESET;
      drive <= 1'b0;
      nine <= 1'b0;
      mack <= 1'b0;
      rd_dir <= 1'b0;
      load <= 1'b0;
    end else begin
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      shift <= next_shift;
      hold <= next_hold;
      wiper <= next_wiper;
      drive <= next_drive;
      nine <= next_nine;
      mack <= next_mack;
      rd_dir <= next_rd_dir;
      load <= next_load;
    end
  end

  // Open drain: only ever pulls low, released from reset
  assign SDA_OUT = 1'b0;
  assign SDA_OE = drive;

  // Wiper and status outputs
  assign WIPER = wiper;
  assign WIPER_LOAD = load;
  assign BUSY = (state != ST_IDLE);

endmodule // wpis_slave

`default_nettype wire

// ---- wpis_slave_sva.sv ----
// Concurrent checks on the pins of the wiper serial slave port
`timescale 1ns/100ps
`default_nettype none
module wpis_slave_sva #(
  parameter [6:0] DEV_CODE = 7'h2a,
  parameter integer PWRUP_CYC = 16
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Bus pins
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  input wire logic SDA_OUT,
  input wire logic SDA_OE,
  // Wiper and status
  input wire logic [7:0] WIPER,
  input wire logic WIPER_LOAD,
  input wire logic BUSY
);
  // One clock and one reset for every check
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);
  // Levels on the data pin and the wiper
  a_wiper_init: assert property ($fell(RST) |-> WIPER == 8'h80)
    else $error("wiper not mid-scale after reset");
  a_open_drain: assert property (SDA_OUT == 1'b0)
    else $error("data pin driven high");
  a_idle_release: assert property (!BUSY |-> !SDA_OE)
    else $error("data pulled while idle");
  a_oe_clock_low: assert property ($changed(SDA_OE) |-> !SCL_IN)
    else $error("data pin moved while clock high");
  // Acknowledge and load timing
  a_ack_hold: assert property ($rose(SDA_OE) |=> SDA_OE [*6])
    else $error("pull on data released early");
  a_load_single: assert property (WIPER_LOAD |=> !WIPER_LOAD)
    else $error("load strobe longer than a cycle");
  a_wiper_guard: assert property ($changed(WIPER) |-> WIPER_LOAD)
    else $error("wiper changed without load");
  a_load_ack: assert property (WIPER_LOAD |-> (!SCL_IN && BUSY) ##[0:1] SDA_OE)
    else $error("load not at acknowledge");
  // Main scenarios
  c_load: cover property (WIPER_LOAD);
  c_ack: cover property ($rose(SDA_OE));
  c_done: cover property ($fell(BUSY));
endmodule // wpis_slave_sva

bind wpis_slave wpis_slave_sva #(.DEV_CODE(DEV_CODE), .PWRUP_CYC(PWRUP_CYC)) u_sva (
  .CLK(CLK), .RST(RST), .SCL_IN(SCL_IN), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT),
  .SDA_OE(SDA_OE), .WIPER(WIPER), .WIPER_LOAD(WIPER_LOAD), .BUSY(BUSY));
`default_nettype wire

// ---- wpis_master_model.sv ----
// Behavioural two-wire bus master facing the slave port
`timescale 1ns/100ps
`default_nettype none
module wpis_master_model (
  // Bus lines
  output logic SCL,
  output logic SDA_LOW,
  input wire logic SDA
);
  // Clock stands high and data released between frames
  initial begin
    SCL = 1'b1;
    SDA_LOW = 1'b0;
  end
  // START or repeated START; odd delay keeps edges off the core clock
  task start;
    begin
      #27 SDA_LOW = 1'b0;
      #24 SCL = 1'b1;
      #32 SDA_LOW = 1'b1;
      #32 SCL = 1'b0;
    end
  endtask
  // STOP, data rising with clock high
  task stop;
    begin
      #24 SDA_LOW = 1'b1;
      #24 SCL = 1'b1;
      #32 SDA_LOW = 1'b0;
      #32;
    end
  endtask
  // One clock pulse in 64 ns, line read 8 ns after the rise
  task bit_io(input logic b, output logic r);
    begin
      #24 SDA_LOW = !b;
      #24 SCL = 1'b1;
      #8 r = SDA;
      #8 SCL = 1'b0;
    end
  endtask
  // Byte MSB first, then the ninth pulse with level a
  task byte_io(input logic [7:0] d, input logic a, output logic [7:0] q, output logic k);
    integer i;
    begin
      for (i = 7; i >= 0; i--) bit_io(d[i], q[i]);
      bit_io(a, k);
    end
  endtask
endmodule // wpis_master_model
`default_nettype wire

// ---- tb_wpis_slave.sv ----
// Self-checking bench for the wiper serial slave port
`timescale 1ns/100ps
`default_nettype none
module tb_wpis_slave;
  // Clock, reset, bus and results
  localparam logic [6:0] DEV = 7'h2a; // Arbitrary device code
  logic clk = 1'b0;
  logic rst = 1'b1;
  wire logic scl, m_low, oe, sda_out, load, busy;
  wire logic [7:0] wiper;
  wire logic sda = ~(oe | m_low); // Pulled-up open-drain line
  integer n_errors = 0;
  integer check_count = 0;
  integer seed = 32'h6e8be4c7;
  integer i;
  integer n_loads = 0;
  integer loads0 = 0;
  logic [7:0] d, q, exp_w;
  logic ack;
  // Clock and instances
  initial forever #4 clk = ~clk;
  wpis_slave #(.DEV_CODE(DEV)) DUT (.CLK(clk), .RST(rst), .SCL_IN(scl), .SDA_IN(sda),
    .SDA_OUT(sda_out), .SDA_OE(oe), .WIPER(wiper), .WIPER_LOAD(load), .BUSY(busy));
  wpis_master_model u_mst (.SCL(scl), .SDA_LOW(m_low), .SDA(sda));
  // Count wiper load strobes so each write to 00h can be held to exactly one
  always @(posedge clk) begin
    if (load === 1'b1)
      n_loads <= n_loads + 1;
  end
  // Compare tasks
  task chk_byte(input logic [7:0] got, input logic [7:0] exp);
    begin
      check_count++;
      if (got !== exp) begin
        n_errors++;
        $display("MISMATCH %0t: byte %h expected %h", $time, got, exp);
      end
    end
  endtask
  task chk_bit(input logic got, input logic exp);
    begin
      check_count++;
      if (got !== exp) begin
        n_errors++;
        $display("MISMATCH %0t: bit %b expected %b", $time, got, exp);
      end
    end
  endtask
  // Identity byte expected by the slave
  function automatic logic [7:0] id_byte(input logic rd);
    return {DEV, rd};
  endfunction
  task put(input logic [7:0] b);
    u_mst.byte_io(b, 1'b1, q, ack);
  endtask
  // Write to address a; only 00h may take effect
  task wr(input logic [7:0] a, input logic [7:0] v);
    begin
      loads0 = n_loads;
      u_mst.start;
      put(id_byte(1'b0));
      chk_bit(ack, 1'b0);
      put(a);
      chk_bit(ack, a != 8'h00);
      put(v);
      chk_bit(ack, a != 8'h00);
      u_mst.stop;
      repeat (6) @(posedge clk);
      chk_bit(busy, 1'b0);
      if (a == 8'h00)
        exp_w = v;
      chk_byte(wiper, exp_w);
      chk_bit(n_loads - loads0 == 1, a == 8'h00);
    end
  endtask
  // Read n bytes after a repeated START; the last is not acknowledged
  task rd(input integer n);
    integer k;
    begin
      u_mst.start;
      put(id_byte(1'b0));
      chk_bit(ack, 1'b0);
      put(8'h00);
      chk_bit(ack, 1'b0);
      u_mst.start;
      put(id_byte(1'b1));
      chk_bit(ack, 1'b0);
      for (k = 1; k <= n; k++) begin
        u_mst.byte_io(8'hff, k == n, q, ack);
        chk_byte(q, exp_w);
      end
      u_mst.stop;
    end
  endtask
  task end_sim;
    begin
      $display("Checks %0d, errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  // Watchdog
  initial begin
    #100000;
    n_errors++;
    end_sim;
  end
  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    exp_w = 8'h80;
    chk_byte(wiper, 8'h80);
    u_mst.start;
    put(id_byte(1'b0));
    chk_bit(ack, 1'b1);
    u_mst.stop;
    for (i = 0; i < 6; i++) begin
      d = $random(seed);
      if (i < 2)
        d = {8{i[0]}};
      wr(8'h00, d);
      rd(2);
    end
    u_mst.start;
    put({~DEV, 1'b0});
    chk_bit(ack, 1'b1);
    put(8'h00);
    chk_bit(ack, 1'b1);
    u_mst.stop;
    wr(8'h01, 8'h3c);
    u_mst.start;
    put(id_byte(1'b0));
    put(8'h00);
    for (i = 0; i < 4; i++) u_mst.bit_io(1'b0, ack);
    u_mst.stop;
    rd(1);
    // Read identity straight after START, no address phase
    u_mst.start;
    put(id_byte(1'b1));
    chk_bit(ack, 1'b0);
    u_mst.byte_io(8'hff, 1'b1, q, ack);
    chk_byte(q, exp_w);
    u_mst.stop;
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    chk_byte(wiper, 8'h80);
    chk_bit(oe, 1'b0);
    rst <= 1'b0;
    exp_w = 8'h80;
    repeat (30) @(posedge clk);
    rd(1);
    end_sim;
  end
endmodule // tb_wpis_slave
`default_nettype wire
